/* File: src/sri_pkg.sv */
// Purpose: shared constants for the system reset and initial-value block
// Assumes: 32-bit register words, byte addresses on the AXI4-Lite slave
// Notes:   register offsets, field positions and register reset values live here; clk_pmc_q resets to 0 in sri_top
package sri_pkg;
	// operating modes strapped at the mode pins
	typedef enum logic [1:0] {
		SRI_MODE_SINGLE0,
		SRI_MODE_SINGLE1,
		SRI_MODE_ROMLESS0,
		SRI_MODE_ROMLESS1
	} sri_mode_t;

	// reset values of the processor core state
	localparam logic [31:0] SRI_RST_ZERO_REG = 32'h0000_0000;
	localparam logic [31:0] SRI_RST_PC       = 32'h0000_0000;
	localparam logic [31:0] SRI_RST_CAUSE    = 32'h0000_0000;
	localparam logic [31:0] SRI_RST_PSW      = 32'h0000_0020;
	// bus and memory control reset values
	localparam logic [15:0] SRI_RST_CSC      = 16'h2C11;
	localparam logic [15:0] SRI_RST_BPC      = 16'h0000;
	localparam logic [15:0] SRI_RST_BSC_NARROW = 16'h0000;
	localparam logic [15:0] SRI_RST_BSC_WIDE = 16'h5555;
	localparam logic [7:0]  SRI_RST_INTERNAL_WAIT_CONTROL     = 8'h77;
	localparam logic [15:0] SRI_RST_BCT      = 16'hCCCC;
	localparam logic [15:0] SRI_RST_DWC      = 16'h3333;
	localparam logic [15:0] SRI_RST_AWC      = 16'h0000;
	localparam logic [15:0] SRI_RST_BCC      = 16'hAAAA;
	// dma and interrupt control reset values
	localparam logic [15:0] SRI_RST_DADC     = 16'h0000;
	localparam logic [7:0]  SRI_RST_BYTE0    = 8'h00;
	localparam logic [15:0] SRI_RST_IMR      = 16'hFFFF;

	// register byte addresses
	localparam logic [7:0] SRI_A_STATUS   = 8'h00;
	localparam logic [7:0] SRI_A_CLKPMC   = 8'h04;
	localparam logic [7:0] SRI_A_PC       = 8'h08;
	localparam logic [7:0] SRI_A_PSW      = 8'h0C;
	localparam logic [7:0] SRI_A_CAUSE    = 8'h10;
	localparam logic [7:0] SRI_A_ZERO     = 8'h14;
	localparam logic [7:0] SRI_A_CSC0     = 8'h20;
	localparam logic [7:0] SRI_A_CSC1     = 8'h24;
	localparam logic [7:0] SRI_A_BPC      = 8'h28;
	localparam logic [7:0] SRI_A_BSC      = 8'h2C;
	localparam logic [7:0] SRI_A_INTERNAL_WAIT_CONTROL     = 8'h30;
	localparam logic [7:0] SRI_A_BCT0     = 8'h34;
	localparam logic [7:0] SRI_A_BCT1     = 8'h38;
	localparam logic [7:0] SRI_A_DWC0     = 8'h3C;
	localparam logic [7:0] SRI_A_DWC1     = 8'h40;
	localparam logic [7:0] SRI_A_AWC      = 8'h44;
	localparam logic [7:0] SRI_A_BCC      = 8'h48;
	localparam logic [7:0] SRI_A_DMA_DISABLE_STATUS     = 8'h4C;
	localparam logic [7:0] SRI_A_DMA_RESTART     = 8'h50;
	localparam logic [7:0] SRI_A_IN_SERVICE_PRIORITY     = 8'h54;
	localparam logic [7:0] SRI_A_DADC0    = 8'h60;
	localparam logic [7:0] SRI_A_DCHC0    = 8'h70;
	localparam logic [7:0] SRI_A_DTFR0    = 8'h80;
	localparam logic [7:0] SRI_A_INTM0    = 8'h90;
	localparam logic [7:0] SRI_A_IMR0     = 8'hA0;
	localparam logic [7:0] SRI_A_STRIDE   = 8'h04;

	// field positions
	localparam int SRI_CLKPMC_BIT = 0;
	localparam int SRI_STAT_RUN   = 0;
	localparam int SRI_STAT_MODE  = 1;

	// axi response codes
	localparam logic [1:0] SRI_RESP_OKAY   = 2'h0;
	localparam logic [1:0] SRI_RESP_SLVERR = 2'h2;
endpackage

/* File: src/sri_rst_sync.sv */
// Purpose: two-flop release synchroniser for the board reset
// Assumes: ext_reset_n is asynchronous to aclk
// Notes:   assertion is taken on the second flop too, release lags two edges
module sri_rst_sync (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ext_reset_n,
	output logic      sys_reset_n
);
	logic meta_q; // first stage, read only by the second flop

	// both stages clear while either reset source is low
	always_ff @(posedge aclk) begin
		if (!aresetn || !ext_reset_n) begin
			meta_q      <= 1'b0;
			sys_reset_n <= 1'b0;
		end else begin
			meta_q      <= 1'b1;
			sys_reset_n <= meta_q;
		end
	end
endmodule

/* File: src/sri_top.sv */
// Purpose: system reset sequencing, pin float control and initial register state
// Assumes: aclk 10 MHz; board holds ext_reset_n low over oscillator settling
// Notes:   registers reachable over AXI4-Lite; writes outside the map get SLVERR
module sri_top #(
	parameter int DMA_CH = 4, // dma channel count
	parameter int IMR_N  = 4, // interrupt mask bank count
	parameter int INTM_N = 3  // external interrupt mode register count
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ext_reset_n,
	input  wire logic [1:0]  mode_pins,
	input  wire logic        bus_wide_strap,
	input  wire logic        osc_clock_in,
	output logic             system_clock_output_pin,
	output logic             system_clock_output_pin_oe,
	output logic             ext_bus_oe,
	output logic             port_pins_oe,
	output logic             bus_ports_control_mode,
	output logic             core_run,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	logic             sys_reset_n;   // synchronised, aligned system reset
	sri_pkg::sri_mode_t mode_q;      // strap sampled while in reset
	logic             bsc_wide_q;    // bus width strap sampled in reset
	logic             clk_pmc_q;     // clock output port enabled by software
	logic [31:0]      zero_reg_q;    // hardwired zero register image
	logic [31:0]      pc_q;          // fetch address
	logic [31:0]      cause_q;       // exception cause
	logic [31:0]      psw_q;         // processor status word
	logic [15:0]      csc_q [2];     // chip area select control
	logic [15:0]      bpc_q;         // peripheral area select
	logic [15:0]      bsc_q;         // bus width configuration
	logic [7:0]       internal_wait_control_q;        // internal wait control
	logic [15:0]      bct_q [2];     // bus cycle type
	logic [15:0]      dwc_q [2];     // data wait control
	logic [15:0]      awc_q;         // address wait control
	logic [15:0]      bcc_q;         // bus cycle control
	logic [7:0]       dma_disable_status_q;        // dma disable status
	logic [7:0]       dma_restart_q;        // dma restart
	logic [7:0]       in_service_priority_q;        // in-service priority
	logic [15:0]      dadc_q [DMA_CH]; // dma addressing control
	logic [7:0]       dchc_q [DMA_CH]; // dma channel control
	logic [7:0]       dtfr_q [DMA_CH]; // dma trigger source
	logic [7:0]       intm_q [INTM_N]; // external interrupt edge mode
	logic [15:0]      imr_q  [IMR_N];  // interrupt mask bank
	// axi write state and read decode
	logic             aw_got_q;
	logic             w_got_q;
	logic [7:0]       aw_addr_q;
	logic [31:0]      w_data_q;
	logic [3:0]       w_strb_q;
	logic             wr_fire;
	logic             wr_hit;
	logic [31:0]      wmask;
	logic             rd_hit;
	logic [31:0]      rd_val;

	// release of the board reset is aligned to aclk before anything sees it
	sri_rst_sync u_sync (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.ext_reset_n (ext_reset_n),
		.sys_reset_n (sys_reset_n)
	);

	// straps are caught by the clock while reset is held, not by the reset itself
	always_ff @(posedge aclk) begin
		if (!sys_reset_n) begin
			mode_q     <= sri_pkg::sri_mode_t'(mode_pins);
			bsc_wide_q <= bus_wide_strap;
		end
	end

	// core comes out of reset one edge after the aligned release
	always_ff @(posedge aclk) begin
		core_run <= sys_reset_n;
	end

	// pin float control: bus and port output enables drop in every mode while reset holds
	always_comb begin
		ext_bus_oe   = core_run;
		port_pins_oe = core_run;
		bus_ports_control_mode = 1'b0;
		if (!core_run) begin
			// single-chip mode 0 leaves the bus ports as plain inputs
			bus_ports_control_mode = (mode_q != sri_pkg::SRI_MODE_SINGLE0);
		end else begin
			bus_ports_control_mode = (mode_q != sri_pkg::SRI_MODE_SINGLE0) || clk_pmc_q;
		end
	end

	// clock output: gated only in single-chip mode 0 until the port is programmed
	always_comb begin
		if (mode_q == sri_pkg::SRI_MODE_SINGLE0) begin
			system_clock_output_pin_oe = clk_pmc_q && core_run;
		end else begin
			system_clock_output_pin_oe = 1'b1;
		end
		system_clock_output_pin = osc_clock_in && system_clock_output_pin_oe;
	end

	// core and control registers: documented values on reset, bus writes after
	// general registers, save registers and ram are not touched here
	always_ff @(posedge aclk) begin
		if (!sys_reset_n) begin
			zero_reg_q <= sri_pkg::SRI_RST_ZERO_REG;
			pc_q       <= sri_pkg::SRI_RST_PC;
			cause_q    <= sri_pkg::SRI_RST_CAUSE;
			psw_q      <= sri_pkg::SRI_RST_PSW;
			clk_pmc_q  <= 1'b0;
			bpc_q      <= sri_pkg::SRI_RST_BPC;
			internal_wait_control_q     <= sri_pkg::SRI_RST_INTERNAL_WAIT_CONTROL;
			bsc_q      <= bsc_wide_q ? sri_pkg::SRI_RST_BSC_WIDE
				: sri_pkg::SRI_RST_BSC_NARROW;
			awc_q      <= sri_pkg::SRI_RST_AWC;
			bcc_q      <= sri_pkg::SRI_RST_BCC;
			dma_disable_status_q     <= sri_pkg::SRI_RST_BYTE0;
			dma_restart_q     <= sri_pkg::SRI_RST_BYTE0;
			in_service_priority_q     <= sri_pkg::SRI_RST_BYTE0;
			for (int i = 0; i < 2; i++) begin
				csc_q[i] <= sri_pkg::SRI_RST_CSC;
				bct_q[i] <= sri_pkg::SRI_RST_BCT;
				dwc_q[i] <= sri_pkg::SRI_RST_DWC;
			end
		end else if (wr_fire) begin
			// zero register ignores writes by design
			case (aw_addr_q)
				sri_pkg::SRI_A_CLKPMC: clk_pmc_q <= wmask[sri_pkg::SRI_CLKPMC_BIT]
					? w_data_q[sri_pkg::SRI_CLKPMC_BIT] : clk_pmc_q;
				sri_pkg::SRI_A_PC:    pc_q    <= (pc_q & ~wmask) | (w_data_q & wmask);
				sri_pkg::SRI_A_PSW:   psw_q   <= (psw_q & ~wmask) | (w_data_q & wmask);
				sri_pkg::SRI_A_CAUSE: cause_q <= (cause_q & ~wmask) | (w_data_q & wmask);
				sri_pkg::SRI_A_CSC0:  csc_q[0] <= w_data_q[15:0];
				sri_pkg::SRI_A_CSC1:  csc_q[1] <= w_data_q[15:0];
				sri_pkg::SRI_A_BPC:   bpc_q   <= w_data_q[15:0];
				sri_pkg::SRI_A_BSC:   bsc_q   <= w_data_q[15:0];
				sri_pkg::SRI_A_INTERNAL_WAIT_CONTROL:  internal_wait_control_q  <= w_data_q[7:0];
				sri_pkg::SRI_A_BCT0:  bct_q[0] <= w_data_q[15:0];
				sri_pkg::SRI_A_BCT1:  bct_q[1] <= w_data_q[15:0];
				sri_pkg::SRI_A_DWC0:  dwc_q[0] <= w_data_q[15:0];
				sri_pkg::SRI_A_DWC1:  dwc_q[1] <= w_data_q[15:0];
				sri_pkg::SRI_A_AWC:   awc_q   <= w_data_q[15:0];
				sri_pkg::SRI_A_BCC:   bcc_q   <= w_data_q[15:0];
				sri_pkg::SRI_A_DMA_DISABLE_STATUS:  dma_disable_status_q  <= w_data_q[7:0];
				sri_pkg::SRI_A_DMA_RESTART:  dma_restart_q  <= w_data_q[7:0];
				sri_pkg::SRI_A_IN_SERVICE_PRIORITY:  in_service_priority_q  <= w_data_q[7:0];
				default: ;
			endcase
		end
	end

	// per-channel and per-bank arrays, one generate loop per group
	genvar g;
	generate
		for (g = 0; g < DMA_CH; g++) begin : g_dma
			localparam logic [7:0] OFS = 8'(g * 4);
			always_ff @(posedge aclk) begin
				if (!sys_reset_n) begin
					dadc_q[g] <= sri_pkg::SRI_RST_DADC;
					dchc_q[g] <= sri_pkg::SRI_RST_BYTE0;
					dtfr_q[g] <= sri_pkg::SRI_RST_BYTE0;
				end else if (wr_fire) begin
					if (aw_addr_q == sri_pkg::SRI_A_DADC0 + OFS) begin
						dadc_q[g] <= w_data_q[15:0];
					end
					if (aw_addr_q == sri_pkg::SRI_A_DCHC0 + OFS) begin
						dchc_q[g] <= w_data_q[7:0];
					end
					if (aw_addr_q == sri_pkg::SRI_A_DTFR0 + OFS) begin
						dtfr_q[g] <= w_data_q[7:0];
					end
				end
			end
		end
		for (g = 0; g < IMR_N; g++) begin : g_imr
			localparam logic [7:0] OFS = 8'(g * 4);
			always_ff @(posedge aclk) begin
				if (!sys_reset_n) begin
					imr_q[g] <= sri_pkg::SRI_RST_IMR;
				end else if (wr_fire && aw_addr_q == sri_pkg::SRI_A_IMR0 + OFS) begin
					imr_q[g] <= w_data_q[15:0];
				end
			end
		end
		for (g = 0; g < INTM_N; g++) begin : g_intm
			localparam logic [7:0] OFS = 8'(g * 4);
			always_ff @(posedge aclk) begin
				if (!sys_reset_n) begin
					intm_q[g] <= sri_pkg::SRI_RST_BYTE0;
				end else if (wr_fire && aw_addr_q == sri_pkg::SRI_A_INTM0 + OFS) begin
					intm_q[g] <= w_data_q[7:0];
				end
			end
		end
	endgenerate

	// byte strobes widened to a bit mask
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{w_strb_q[b]}};
		end
	end

	// address decode, shared by read and write
	function automatic logic mapped(input logic [7:0] a);
		logic hit;
		hit = 1'b0;
		if (a <= sri_pkg::SRI_A_IN_SERVICE_PRIORITY && a[1:0] == 2'h0) hit = 1'b1;
		if (a >= sri_pkg::SRI_A_DADC0 && a < sri_pkg::SRI_A_DADC0 + 8'(DMA_CH * 4)) hit = 1'b1;
		if (a >= sri_pkg::SRI_A_DCHC0 && a < sri_pkg::SRI_A_DCHC0 + 8'(DMA_CH * 4)) hit = 1'b1;
		if (a >= sri_pkg::SRI_A_DTFR0 && a < sri_pkg::SRI_A_DTFR0 + 8'(DMA_CH * 4)) hit = 1'b1;
		if (a >= sri_pkg::SRI_A_INTM0 && a < sri_pkg::SRI_A_INTM0 + 8'(INTM_N * 4)) hit = 1'b1;
		if (a >= sri_pkg::SRI_A_IMR0 && a < sri_pkg::SRI_A_IMR0 + 8'(IMR_N * 4)) hit = 1'b1;
		if (a[1:0] != 2'h0) hit = 1'b0;
		if (a > sri_pkg::SRI_A_IN_SERVICE_PRIORITY && a < sri_pkg::SRI_A_DADC0) hit = 1'b0;
		return hit;
	endfunction

	assign wr_hit = mapped(aw_addr_q);
	assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
	assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_q && !s_axi_bvalid;

	// write channel: address and data latched in either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q     <= 1'b0;
			w_got_q      <= 1'b0;
			aw_addr_q    <= 8'h00;
			w_data_q     <= 32'h0000_0000;
			w_strb_q     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= sri_pkg::SRI_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q  <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q  <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? sri_pkg::SRI_RESP_OKAY : sri_pkg::SRI_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read mux over the whole map
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = mapped(s_axi_araddr);
		case (s_axi_araddr)
			sri_pkg::SRI_A_STATUS: begin
				rd_val[sri_pkg::SRI_STAT_RUN] = core_run;
				rd_val[sri_pkg::SRI_STAT_MODE +: 2] = mode_q;
			end
			sri_pkg::SRI_A_CLKPMC: rd_val[sri_pkg::SRI_CLKPMC_BIT] = clk_pmc_q;
			sri_pkg::SRI_A_PC:    rd_val = pc_q;
			sri_pkg::SRI_A_PSW:   rd_val = psw_q;
			sri_pkg::SRI_A_CAUSE: rd_val = cause_q;
			sri_pkg::SRI_A_ZERO:  rd_val = zero_reg_q;
			sri_pkg::SRI_A_CSC0:  rd_val[15:0] = csc_q[0];
			sri_pkg::SRI_A_CSC1:  rd_val[15:0] = csc_q[1];
			sri_pkg::SRI_A_BPC:   rd_val[15:0] = bpc_q;
			sri_pkg::SRI_A_BSC:   rd_val[15:0] = bsc_q;
			sri_pkg::SRI_A_INTERNAL_WAIT_CONTROL:  rd_val[7:0] = internal_wait_control_q;
			sri_pkg::SRI_A_BCT0:  rd_val[15:0] = bct_q[0];
			sri_pkg::SRI_A_BCT1:  rd_val[15:0] = bct_q[1];
			sri_pkg::SRI_A_DWC0:  rd_val[15:0] = dwc_q[0];
			sri_pkg::SRI_A_DWC1:  rd_val[15:0] = dwc_q[1];
			sri_pkg::SRI_A_AWC:   rd_val[15:0] = awc_q;
			sri_pkg::SRI_A_BCC:   rd_val[15:0] = bcc_q;
			sri_pkg::SRI_A_DMA_DISABLE_STATUS:  rd_val[7:0] = dma_disable_status_q;
			sri_pkg::SRI_A_DMA_RESTART:  rd_val[7:0] = dma_restart_q;
			sri_pkg::SRI_A_IN_SERVICE_PRIORITY:  rd_val[7:0] = in_service_priority_q;
			default: begin
				for (int i = 0; i < DMA_CH; i++) begin
					if (s_axi_araddr == sri_pkg::SRI_A_DADC0 + 8'(i * 4)) rd_val[15:0] = dadc_q[i];
					if (s_axi_araddr == sri_pkg::SRI_A_DCHC0 + 8'(i * 4)) rd_val[7:0] = dchc_q[i];
					if (s_axi_araddr == sri_pkg::SRI_A_DTFR0 + 8'(i * 4)) rd_val[7:0] = dtfr_q[i];
				end
				for (int i = 0; i < INTM_N; i++) begin
					if (s_axi_araddr == sri_pkg::SRI_A_INTM0 + 8'(i * 4)) rd_val[7:0] = intm_q[i];
				end
				for (int i = 0; i < IMR_N; i++) begin
					if (s_axi_araddr == sri_pkg::SRI_A_IMR0 + 8'(i * 4)) rd_val[15:0] = imr_q[i];
				end
			end
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	// read channel: one cycle to answer, data held until taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= sri_pkg::SRI_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_hit ? rd_val : 32'h0000_0000;
			s_axi_rresp  <= rd_hit ? sri_pkg::SRI_RESP_OKAY : sri_pkg::SRI_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

/* File: bench/sri_board_model.sv */
// Purpose: board-level reset source standing in front of the reset pin
// Assumes: the oscillator settles within SETTLE cycles of power-up
// Notes:   a request from the bench restarts the full hold, never a short one
module sri_board_model #(
	parameter int SETTLE = 10 // cycles the pin stays low per reset
) (
	input  wire logic aclk,
	input  wire logic hold_req,
	output logic      ext_reset_n
);
	int cnt = SETTLE; // low at power-up, before the first edge
	// count down the hold; a request restarts it
	always @(posedge aclk) begin
		if (hold_req)
			cnt <= SETTLE;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
	// pin released only once the whole settling span has passed
	assign ext_reset_n = (cnt == 0);
endmodule

/* File: bench/sri_top_chk.sv */
// Purpose: port-level assertions for the reset sequencer
// Assumes: mode straps change only while aresetn is low
// Notes:   one clock domain, so default clocking and disable are used
module sri_top_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        ext_reset_n,
	input wire logic [1:0]  mode_pins,
	input wire logic        osc_clock_in,
	input wire logic        system_clock_output_pin,
	input wire logic        system_clock_output_pin_oe,
	input wire logic        ext_bus_oe,
	input wire logic        port_pins_oe,
	input wire logic        bus_ports_control_mode,
	input wire logic        core_run,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	float_pins_a: assert property (!core_run |-> !ext_bus_oe && !port_pins_oe)
		else $error("pins driven while core halted");
	bus_float_a: assert property (!ext_reset_n [*4] |-> !ext_bus_oe)
		else $error("external bus driven in reset");
	core_halt_a: assert property (!ext_reset_n [*4] |-> !core_run)
		else $error("core running in reset");
	clk_run_a: assert property (mode_pins != 2'h0 |-> system_clock_output_pin_oe)
		else $error("clock pin not driven");
	clk_gate_a: assert property (mode_pins == 2'h0 && !core_run |-> !system_clock_output_pin_oe)
		else $error("clock pin driven in mode 0 reset");
	clk_pin_a: assert property (system_clock_output_pin == (osc_clock_in && system_clock_output_pin_oe))
		else $error("clock pin level wrong");
	core_start_a: assert property ($rose(ext_reset_n) |-> !core_run ##[1:4] core_run)
		else $error("core start timing wrong");
	ctl_mode_a: assert property (!core_run |-> bus_ports_control_mode == (mode_pins != 2'h0))
		else $error("bus port mode wrong in reset");
	write_ans_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> ##1 s_axi_bvalid) else $error("write answer late");
	read_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	cover property (mode_pins == 2'h0 && system_clock_output_pin_oe);
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	cover property ($rose(core_run));
endmodule

bind sri_top sri_top_chk u_sri_top_chk (.aclk, .aresetn, .ext_reset_n, .mode_pins, .osc_clock_in,
	.system_clock_output_pin, .system_clock_output_pin_oe, .ext_bus_oe, .port_pins_oe,
	.bus_ports_control_mode, .core_run, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

/* File: bench/sri_top_test.sv */
// Purpose: self-checking bench for the reset sequencer and its registers
// Assumes: aclk 100 ns; inputs change by non-blocking assignment at posedge
// Notes:   an associative array holds every expected register value except the status word
module sri_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk = 1'b0;           // 10 MHz clock
	logic        aresetn = 1'b0;        // bus reset, low at start
	logic        hold_req = 1'b0;       // asks the board model for a reset
	logic        ext_reset_n;           // from the board model
	logic [1:0]  mode_pins = 2'h0;      // strap, changed only under aresetn
	logic        bus_wide_strap = 1'b0; // bus width strap
	logic        osc_clock_in = 1'b0;   // toggles each rising edge
	logic        system_clock_output_pin, system_clock_output_pin_oe, ext_bus_oe;
	logic        port_pins_oe, bus_ports_control_mode, core_run;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] m [logic [7:0]];      // expected register contents
	int          n_mismatch = 0;
	int          total_checks = 0;

	sri_board_model u_sri_board_model (.aclk, .hold_req, .ext_reset_n);
	sri_top u_sri_top (.aclk, .aresetn, .ext_reset_n, .mode_pins, .bus_wide_strap, .osc_clock_in,
		.system_clock_output_pin, .system_clock_output_pin_oe, .ext_bus_oe, .port_pins_oe,
		.bus_ports_control_mode, .core_run, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	// clock: half period 50 ns
	initial begin
		forever #50 aclk = ~aclk;
	end
	// internal clock source, stepped on the edge so it never races sampling
	always @(posedge aclk) osc_clock_in <= ~osc_clock_in;

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// writable width per register; zero register keeps nothing
	function automatic logic [31:0] wmask(input logic [7:0] a);
		if (a == 8'h04) return 32'h1;
		if (a inside {8'h08, 8'h0C, 8'h10}) return 32'hFFFFFFFF;
		if (a == 8'h14) return 32'h0;
		if (a inside {8'h30, 8'h4C, 8'h50, 8'h54} || (a >= 8'h70 && a < 8'hA0)) return 32'hFF;
		return 32'hFFFF;
	endfunction

	// reset image of the whole map
	task automatic mreset(input logic wide);
		m.delete();
		foreach (m[a]) m[a] = 32'h0;
		for (int a = 8'h04; a <= 8'h54; a += 4) m[a[7:0]] = 32'h0;
		for (int a = 8'h18; a <= 8'h1C; a += 4) m.delete(a[7:0]);
		m[8'h0C] = 32'h20;
		m[8'h20] = 32'h2C11;
		m[8'h24] = 32'h2C11;
		m[8'h2C] = wide ? 32'h5555 : 32'h0;
		m[8'h30] = 32'h77;
		m[8'h34] = 32'hCCCC;
		m[8'h38] = 32'hCCCC;
		m[8'h3C] = 32'h3333;
		m[8'h40] = 32'h3333;
		m[8'h48] = 32'hAAAA;
		for (int n = 0; n < 4; n++) begin
			m[8'h60 + 4 * n] = 32'h0;
			m[8'h70 + 4 * n] = 32'h0;
			m[8'h80 + 4 * n] = 32'h0;
			m[8'hA0 + 4 * n] = 32'hFFFF;
			if (n < 3) m[8'h90 + 4 * n] = 32'h0;
		end
	endtask

	// write master: address and data offered together, each dropped when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			ad = ad | s_axi_awready;
			wd = wd | s_axi_wready;
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		axr(a, d, r);
		chk(d, exp);
		chk(r, 2'h0);
	endtask

	// whole map against the model, then the status word
	task automatic chk_all();
		foreach (m[a]) rdchk(a, m[a]);
		rdchk(8'h00, {29'h0, mode_pins, 1'b1});
	endtask

	task automatic do_reset(input logic [1:0] md, input logic wide);
		@(posedge aclk);
		aresetn <= 1'b0;
		mode_pins <= md;
		bus_wide_strap <= wide;
		repeat (12) @(posedge aclk);
		chk(ext_bus_oe, 1'b0);
		chk(port_pins_oe, 1'b0);
		chk(core_run, 1'b0);
		chk(system_clock_output_pin_oe, md != 2'h0);
		chk(bus_ports_control_mode, md != 2'h0);
		aresetn <= 1'b1;
		repeat (8) @(posedge aclk);
		chk(core_run, 1'b1);
		mreset(wide);
		rdchk(8'h08, 32'h0);
		rdchk(8'h0C, 32'h20);
		rdchk(8'h20, 32'h2C11);
		rdchk(8'h2C, wide ? 32'h5555 : 32'h0);
		rdchk(8'h3C, 32'h3333);
		rdchk(8'h70, 32'h0);
		rdchk(8'hAC, 32'hFFFF);
	endtask

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		void'($urandom(44));
		for (int md = 0; md < 4; md++) begin
			do_reset(md[1:0], md[0]);
			chk_all();
			if (md == 0) begin
				chk(system_clock_output_pin_oe, 1'b0);
				axw(8'h04, 32'h1, 2'h0);
				@(posedge aclk);
				chk(system_clock_output_pin_oe, 1'b1);
			end
			foreach (m[a]) begin
				d = $urandom;
				axw(a, d, 2'h0);
				m[a] = d & wmask(a);
			end
			axw(8'hFC, $urandom, 2'h2);
			axw(8'h21, $urandom, 2'h2);
			axr(8'hFC, d, r);
			chk(d, 32'h0);
			chk(r, 2'h2);
			chk_all();
		end
		// board reset in mid-run brings the core and every register back to reset
		@(posedge aclk);
		hold_req <= 1'b1;
		@(posedge aclk);
		hold_req <= 1'b0;
		repeat (4) @(posedge aclk);
		chk(core_run, 1'b0);
		chk(ext_bus_oe, 1'b0);
		repeat (20) @(posedge aclk);
		chk(core_run, 1'b1);
		mreset(1'b1);
		chk_all();
		summarize();
	end

	// watchdog: the whole run needs well under 20000 cycles
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		summarize();
	end
endmodule
